// ==== psp_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External processor on the byte bus
// ----------------------------------------
module psp_cpu_model
  import psp_pkg::*;
(
  input wire logic i_clock,
  output logic [2:0] o_ctrl_n,
  output logic [7:0] o_bus
);
  initial begin
    o_ctrl_n = 3'h7;
    o_bus = 8'h00;
  end

  // Data is held a few clocks past the strobe so the slow sync sees it
  task automatic ext_write(input logic [7:0] data, input int hold);
    @(posedge i_clock);
    o_bus <= data;
    o_ctrl_n <= 3'h1;
    repeat (hold) @(posedge i_clock);
    o_ctrl_n <= 3'h7;
    repeat (3) @(posedge i_clock);
    o_bus <= ~data;
  endtask : ext_write

  task automatic start_read();
    @(posedge i_clock);
    o_ctrl_n <= 3'h2;
  endtask : start_read

  task automatic end_read();
    @(posedge i_clock);
    o_ctrl_n <= 3'h7;
  endtask : end_read
endmodule : psp_cpu_model
`default_nettype wire

// ==== psp_done_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
module psp_done_seq
  import psp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_end,
  input wire logic [1:0] i_phase,
  output logic o_fire
);
  psp_done_state_t state;
  // After a cycle ends, wait for the next phase two, then fire on phase four
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= PSP_IDLE;
      o_fire <= 1'b0;
    end else begin
      o_fire <= 1'b0;
      case (state)
        PSP_IDLE: if (i_end) state <= PSP_WAIT_Q2;
        PSP_WAIT_Q2: if (i_phase == PHASE_TWO) state <= PSP_WAIT_Q4;
        PSP_WAIT_Q4: begin
          if (i_phase == PHASE_FOUR) begin
            o_fire <= 1'b1;
            state <= PSP_IDLE;
          end
        end
        default: state <= PSP_IDLE;
      endcase
    end
  end
endmodule : psp_done_seq
`default_nettype wire

// ==== psp_pkg.sv ====
package psp_pkg;
  // Register offsets, byte addressing on the plain register port
  localparam logic [7:0] ADDR_DATA_PORT = 8'h08;
  localparam logic [7:0] ADDR_CTRL_PORT = 8'h09;
  localparam logic [7:0] ADDR_CORE_INT = 8'h0b;
  localparam logic [7:0] ADDR_PERIPH_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_DIR_STATUS = 8'h89;
  localparam logic [7:0] ADDR_DATA_DIR = 8'h88;
  localparam logic [7:0] ADDR_PERIPH_EN = 8'h8c;
  localparam logic [7:0] ADDR_ANALOG_CFG = 8'h9f;
  // Field positions
  localparam int BIT_IBF = 7;
  localparam int BIT_OBF = 6;
  localparam int BIT_INPUT_OVERFLOW = 5;
  localparam int BIT_MODE = 4;
  localparam int BIT_IRQ = 7;
  localparam int BIT_GIE = 7;
  localparam int BIT_PEIE = 6;
  // Reset values
  localparam logic [2:0] CTRL_DIR_RESET = 3'h7;
  localparam logic [7:0] DATA_DIR_RESET = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] ANALOG_DIGITAL = 3'h7;
  // Phase clock: four core cycles per instruction cycle
  localparam logic [1:0] PHASE_TWO = 2'h1;
  localparam logic [1:0] PHASE_FOUR = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } psp_reg_req_t;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
  } psp_strobe_t;

  typedef enum logic [1:0] {
    PSP_IDLE,
    PSP_WAIT_Q2,
    PSP_WAIT_Q4
  } psp_done_state_t;
endpackage : psp_pkg

// ==== psp_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module psp_sync
  import psp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire psp_strobe_t i_async,
  output psp_strobe_t o_sync
);
  psp_strobe_t meta;
  // Idle strobes are high, so reset to the inactive level
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= '1;
      o_sync <= '1;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : psp_sync
`default_nettype wire

// ==== psp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module psp_top
  import psp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_data_pins,
  output logic [7:0] o_data_pins,
  output logic [7:0] o_data_oe,
  input wire logic [2:0] i_ctrl_pins,
  output logic [2:0] o_ctrl_pins,
  output logic [2:0] o_ctrl_oe,
  output logic o_irq
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  psp_reg_req_t req;
  logic [7:0] out_latch;
  logic [7:0] in_latch;
  logic [7:0] data_dir;
  logic [2:0] ctrl_dir;
  logic [2:0] ctrl_latch;
  logic [2:0] analog_cfg;
  logic slave_port_mode;
  logic input_buffer_full;
  logic output_buffer_full;
  logic input_overflow;
  logic slave_port_irq_flag;
  logic slave_port_irq_enable;
  logic [7:0] periph_flags_other;
  logic [7:0] periph_en_other;
  logic [7:0] core_int;
  logic [1:0] phase;
  psp_strobe_t pins_raw;
  psp_strobe_t strb;
  logic wr_act;
  logic wr_act_d;
  logic rd_act;
  logic rd_act_d;
  logic wr_end;
  logic rd_end;
  logic wr_start;
  logic rd_start;
  logic wr_fire;
  logic rd_fire;
  logic fw_rd_data;
  logic fw_wr_data;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  function automatic logic hit(input psp_reg_req_t r, input logic [7:0] a);
    hit = (r.addr == a);
  endfunction : hit

  assign fw_rd_data = req.rd && hit(req, ADDR_DATA_PORT);
  assign fw_wr_data = req.wr && hit(req, ADDR_DATA_PORT);

  // ------------------------------------------------------------
  // Phase counter and strobe synchronisation
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) phase <= 2'h0;
    else phase <= phase + 2'h1;
  end

  // Control pin 0 is read, 1 is write, 2 is chip select
  assign pins_raw = '{cs_n: i_ctrl_pins[2], wr_n: i_ctrl_pins[1],
                      rd_n: i_ctrl_pins[0]};

  psp_sync u_sync (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_async(pins_raw),
    .o_sync(strb)
  );

  // Strobes only count in slave mode; level based detection
  assign wr_act = slave_port_mode && !strb.cs_n && !strb.wr_n;
  assign rd_act = slave_port_mode && !strb.cs_n && !strb.rd_n;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_act_d <= 1'b0;
      rd_act_d <= 1'b0;
    end else begin
      wr_act_d <= wr_act;
      rd_act_d <= rd_act;
    end
  end

  assign wr_start = wr_act && !wr_act_d;
  assign rd_start = rd_act && !rd_act_d;
  assign wr_end = !wr_act && wr_act_d;
  assign rd_end = !rd_act && rd_act_d;

  psp_done_seq u_wr_done (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_end(wr_end),
    .i_phase(phase),
    .o_fire(wr_fire)
  );

  psp_done_seq u_rd_done (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_end(rd_end),
    .i_phase(phase),
    .o_fire(rd_fire)
  );

  // ------------------------------------------------------------
  // Data latches
  // ------------------------------------------------------------
  // Data pins are still sampled while write is low; the last sample
  // before the strobe rises is what the latch keeps.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) in_latch <= ZERO_BYTE;
    else if (wr_act) in_latch <= i_data_pins;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) out_latch <= ZERO_BYTE;
    else if (fw_wr_data) out_latch <= req.wdata;
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) input_buffer_full <= 1'b0;
    else if (!slave_port_mode) input_buffer_full <= 1'b0;
    else if (wr_fire) input_buffer_full <= 1'b1;
    else if (fw_rd_data) input_buffer_full <= 1'b0;
  end

  // Read start clears even if firmware writes the same cycle
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) output_buffer_full <= 1'b0;
    else if (!slave_port_mode) output_buffer_full <= 1'b0;
    else if (rd_start) output_buffer_full <= 1'b0;
    else if (fw_wr_data) output_buffer_full <= 1'b1;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) input_overflow <= 1'b0;
    else if (wr_start && input_buffer_full) input_overflow <= 1'b1;
    else if (req.wr && hit(req, ADDR_DIR_STATUS) && !req.wdata[BIT_INPUT_OVERFLOW])
      input_overflow <= 1'b0;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slave_port_mode <= 1'b0;
      ctrl_dir <= CTRL_DIR_RESET;
    end else if (req.wr && hit(req, ADDR_DIR_STATUS)) begin
      slave_port_mode <= req.wdata[BIT_MODE];
      ctrl_dir <= req.wdata[2:0];
    end
  end

  // Hardware set wins over a firmware clear in the same cycle
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) slave_port_irq_flag <= 1'b0;
    else if (wr_fire || rd_fire) slave_port_irq_flag <= 1'b1;
    else if (req.wr && hit(req, ADDR_PERIPH_FLAGS))
      slave_port_irq_flag <= req.wdata[BIT_IRQ];
  end

  // ------------------------------------------------------------
  // Plain storage registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slave_port_irq_enable <= 1'b0;
      periph_flags_other <= ZERO_BYTE;
      periph_en_other <= ZERO_BYTE;
      core_int <= ZERO_BYTE;
      analog_cfg <= ANALOG_DIGITAL ^ ANALOG_DIGITAL;
      data_dir <= DATA_DIR_RESET;
      ctrl_latch <= CTRL_DIR_RESET ^ CTRL_DIR_RESET;
    end else if (req.wr) begin
      if (hit(req, ADDR_PERIPH_EN)) begin
        slave_port_irq_enable <= req.wdata[BIT_IRQ];
        periph_en_other <= {1'b0, req.wdata[6:0]};
      end
      if (hit(req, ADDR_PERIPH_FLAGS))
        periph_flags_other <= {1'b0, req.wdata[6:0]};
      if (hit(req, ADDR_CORE_INT)) core_int <= req.wdata;
      if (hit(req, ADDR_ANALOG_CFG)) analog_cfg <= req.wdata[2:0];
      if (hit(req, ADDR_DATA_DIR)) data_dir <= req.wdata;
      if (hit(req, ADDR_CTRL_PORT)) ctrl_latch <= req.wdata[2:0];
    end
  end

  // ------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) o_rdata <= ZERO_BYTE;
    else if (req.rd) begin
      case (req.addr)
        ADDR_DATA_PORT: o_rdata <= slave_port_mode ? in_latch : i_data_pins;
        ADDR_CTRL_PORT: o_rdata <= {5'h00, i_ctrl_pins};
        ADDR_CORE_INT: o_rdata <= core_int;
        ADDR_PERIPH_FLAGS: o_rdata <= {slave_port_irq_flag,
                                       periph_flags_other[6:0]};
        ADDR_DIR_STATUS: o_rdata <= {input_buffer_full, output_buffer_full,
                                     input_overflow, slave_port_mode, 1'b0,
                                     ctrl_dir};
        ADDR_DATA_DIR: o_rdata <= data_dir;
        ADDR_PERIPH_EN: o_rdata <= {slave_port_irq_enable,
                                    periph_en_other[6:0]};
        ADDR_ANALOG_CFG: o_rdata <= {5'h00, analog_cfg};
        default: o_rdata <= ZERO_BYTE;
      endcase
    end else o_rdata <= ZERO_BYTE;
  end

  // ------------------------------------------------------------
  // Pins and interrupt
  // ------------------------------------------------------------
  // Drive follows synchronised strobes, so it lags the pins by three
  // clocks; an external reader must allow for that.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data_pins <= ZERO_BYTE;
      o_data_oe <= ZERO_BYTE;
      o_ctrl_pins <= 3'h0;
      o_ctrl_oe <= 3'h0;
      o_irq <= 1'b0;
    end else begin
      o_data_pins <= out_latch;
      if (slave_port_mode) o_data_oe <= {8{rd_act}};
      else o_data_oe <= ~data_dir;
      o_ctrl_pins <= ctrl_latch;
      o_ctrl_oe <= slave_port_mode ? 3'h0 : ~ctrl_dir;
      o_irq <= slave_port_irq_flag && slave_port_irq_enable;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_ibf_on_fire;
    @(posedge i_clock) disable iff (!i_arst_n)
      wr_fire && slave_port_mode |=> input_buffer_full;
  endproperty
  a_ibf_on_fire: assert property (p_ibf_on_fire)
    else $error("input full not set after write");

  property p_fire_phase;
    @(posedge i_clock) disable iff (!i_arst_n)
      wr_fire |-> $past(phase) == PHASE_FOUR;
  endproperty
  a_fire_phase: assert property (p_fire_phase)
    else $error("write done not on phase four");

  property p_fire_bound;
    @(posedge i_clock) disable iff (!i_arst_n)
      wr_end |-> ##[2:9] wr_fire;
  endproperty
  a_fire_bound: assert property (p_fire_bound)
    else $error("write done too late");

  // Read completion waits for phase two, then fires on phase four
  property p_rd_bound;
    @(posedge i_clock) disable iff (!i_arst_n)
      rd_end |-> ##[4:7] rd_fire;
  endproperty
  a_rd_bound: assert property (p_rd_bound)
    else $error("read done not on time");

  property p_irq_flag;
    @(posedge i_clock) disable iff (!i_arst_n)
      (wr_fire || rd_fire) |=> slave_port_irq_flag;
  endproperty
  a_irq_flag: assert property (p_irq_flag)
    else $error("irq flag not set");

  property p_obf_clear;
    @(posedge i_clock) disable iff (!i_arst_n)
      rd_start |=> !output_buffer_full;
  endproperty
  a_obf_clear: assert property (p_obf_clear)
    else $error("output full not cleared on read");

  property p_mode_off;
    @(posedge i_clock) disable iff (!i_arst_n)
      !slave_port_mode |=> !input_buffer_full && !output_buffer_full;
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("full flag set outside slave mode");

  property p_ovf;
    @(posedge i_clock) disable iff (!i_arst_n)
      wr_start && input_buffer_full |=> input_overflow;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow missed");

  property p_irq_out;
    @(posedge i_clock) disable iff (!i_arst_n)
      ##1 o_irq == $past(slave_port_irq_flag && slave_port_irq_enable);
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("interrupt output mismatch");

  property p_ibf_hold;
    @(posedge i_clock) disable iff (!i_arst_n)
      input_buffer_full && slave_port_mode && !fw_rd_data |=>
        input_buffer_full;
  endproperty
  a_ibf_hold: assert property (p_ibf_hold)
    else $error("input full dropped without read");

  c_write: cover property (@(posedge i_clock) wr_fire);
  c_read: cover property (@(posedge i_clock) rd_fire);
  c_ovf: cover property (@(posedge i_clock) $rose(input_overflow));
endmodule : psp_top
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
  import psp_pkg::*;
;
  logic i_clock, i_arst_n, i_wr, i_rd, irq;
  logic [7:0] i_addr, i_wdata, rdata, data_out, data_oe, cpu_bus, bus;
  logic [2:0] ctrl_out, ctrl_oe, cpu_ctrl, ctrl;
  int num_errors, cmp_count;

  // Wire level: whoever enables wins, else the processor's value
  assign bus = (data_oe & data_out) | (~data_oe & cpu_bus);
  assign ctrl = (ctrl_oe & ctrl_out) | (~ctrl_oe & cpu_ctrl);

  psp_top i_psp_top (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(rdata), .i_data_pins(bus), .o_data_pins(data_out),
    .o_data_oe(data_oe), .i_ctrl_pins(ctrl), .o_ctrl_pins(ctrl_out),
    .o_ctrl_oe(ctrl_oe), .o_irq(irq));
  psp_cpu_model i_psp_cpu_model (.i_clock(i_clock), .o_ctrl_n(cpu_ctrl),
    .o_bus(cpu_bus));

  always #4 i_clock = ~i_clock;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic reg_wr(input logic [7:0] addr, data);
    @(posedge i_clock);
    i_addr <= addr;
    i_wdata <= data;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_chk(input logic [7:0] addr, exp);
    @(posedge i_clock);
    i_addr <= addr;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    check($sformatf("reg %h", addr), rdata, exp);
  endtask : reg_chk

  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : settle

  task automatic ext_wr(input logic [7:0] data, input int hold);
    i_psp_cpu_model.ext_write(data, hold);
    settle(12);
  endtask : ext_wr

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    reg_chk(ADDR_DIR_STATUS, 8'h07);
    reg_chk(ADDR_PERIPH_FLAGS, 8'h00);
    reg_chk(ADDR_PERIPH_EN, 8'h00);
    reg_wr(8'h55, 8'hff);
    reg_chk(8'h55, 8'h00);
  endtask : t_reset

  task automatic t_setup();
    reg_wr(ADDR_ANALOG_CFG, {5'h00, ANALOG_DIGITAL});
    reg_wr(ADDR_DATA_DIR, 8'h00);
    reg_wr(ADDR_DIR_STATUS, 8'h17);
    settle(2);
    check("ctrl oe", {5'h00, ctrl_oe}, 8'h00);
    check("data oe", data_oe, 8'h00);
    reg_wr(ADDR_DATA_PORT, 8'ha5);
    reg_chk(ADDR_DIR_STATUS, 8'h57);
  endtask : t_setup

  task automatic t_ext_write();
    ext_wr(8'h3c, 4);
    reg_chk(ADDR_DIR_STATUS, 8'hd7);
    reg_chk(ADDR_PERIPH_FLAGS, 8'h80);
    check("irq masked", {7'h00, irq}, 8'h00);
    reg_wr(ADDR_PERIPH_EN, 8'h80);
    settle(2);
    check("irq on", {7'h00, irq}, 8'h01);
  endtask : t_ext_write

  task automatic t_overflow();
    ext_wr(8'h99, 8);
    reg_chk(ADDR_DIR_STATUS, 8'hf7);
    reg_chk(ADDR_DATA_PORT, 8'h99);
    reg_chk(ADDR_DIR_STATUS, 8'h77);
    reg_wr(ADDR_DIR_STATUS, 8'h97);
    reg_chk(ADDR_DIR_STATUS, 8'h57);
    reg_wr(ADDR_PERIPH_FLAGS, 8'h00);
    reg_chk(ADDR_PERIPH_FLAGS, 8'h00);
    settle(2);
    check("irq off", {7'h00, irq}, 8'h00);
  endtask : t_overflow

  task automatic t_ext_read();
    i_psp_cpu_model.start_read();
    settle(4);
    check("bus", bus, 8'ha5);
    check("oe read", data_oe, 8'hff);
    reg_chk(ADDR_DIR_STATUS, 8'h17);
    i_psp_cpu_model.end_read();
    settle(14);
    check("oe idle", data_oe, 8'h00);
    reg_chk(ADDR_PERIPH_FLAGS, 8'h80);
    reg_chk(ADDR_DIR_STATUS, 8'h17);
    reg_wr(ADDR_DATA_PORT, 8'h11);
    reg_chk(ADDR_DIR_STATUS, 8'h57);
  endtask : t_ext_read

  task automatic t_mode_off();
    ext_wr(8'h42, 4);
    ext_wr(8'h43, 4);
    reg_chk(ADDR_DIR_STATUS, 8'hf7);
    reg_wr(ADDR_DIR_STATUS, 8'h27);
    reg_chk(ADDR_DIR_STATUS, 8'h27);
    reg_chk(ADDR_DATA_PORT, 8'h11);
    reg_chk(ADDR_CTRL_PORT, 8'h07);
    reg_wr(ADDR_CTRL_PORT, 8'h05);
    settle(2);
    check("ctrl pins", {5'h00, ctrl_out}, 8'h05);
    reg_wr(ADDR_PERIPH_FLAGS, 8'h00);
    ext_wr(8'h5a, 4);
    reg_chk(ADDR_PERIPH_FLAGS, 8'h00);
    reg_wr(ADDR_DIR_STATUS, 8'h07);
    reg_chk(ADDR_DIR_STATUS, 8'h07);
  endtask : t_mode_off

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    i_clock = 1'b0;
    i_arst_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    repeat (12) @(posedge i_clock);
    i_arst_n <= 1'b1;
    t_reset();
    t_setup();
    t_ext_write();
    t_overflow();
    t_ext_read();
    t_mode_off();
    end_of_test();
  end

  // Whole run needs well under a thousand clocks
  initial begin
    repeat (20000) @(posedge i_clock);
    num_errors++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
